// ==== logic/ipw_pkg.sv ====
package ipw_pkg;
  // ==========================================================
  // I/O port addresses
  localparam logic [15:0] IDX_PORT_ADDR  = 16'h002e;
  localparam logic [15:0] DATA_PORT_ADDR = 16'h002f;
  // ==========================================================
  // Key values written to the index port
  localparam logic [7:0] KEY_UNLOCK = 8'h87;
  localparam logic [7:0] KEY_LOCK   = 8'haa;
  // ==========================================================
  // Register indices, watchdog unit number and activate value
  localparam logic [7:0] IDX_UNIT_SEL = 8'h07;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_CNT_CFG  = 8'hf5;
  localparam logic [7:0] IDX_COUNT    = 8'hf6;
  localparam logic [7:0] IDX_RELOAD   = 8'hf7;
  localparam logic [7:0] UNIT_SUPV    = 8'h08;
  localparam logic [7:0] ACT_ON       = 8'h01;
  // ==========================================================
  // Field positions
  localparam int CFG_MIN_BIT   = 3;
  localparam int CFG_FAST_BIT  = 4;
  localparam int RLD_MOUSE_BIT = 7;
  localparam int RLD_KBD_BIT   = 6;
  localparam int RLD_FORCE_BIT = 5;
  localparam int RLD_STAT_BIT  = 4;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_UNIT_SEL = 8'h00;
  localparam logic [7:0] RST_ACTIVATE = 8'h00;
  localparam logic [7:0] RST_CNT_CFG  = 8'h00;
  localparam logic [7:0] RST_COUNT    = 8'h00;
  localparam logic [7:0] RST_RELOAD   = 8'h00;
  // ==========================================================
  // Timing: unit tick derived from a 40 MHz clock
  localparam longint CLK_HZ         = 40000000;
  localparam longint MS_PER_SEC     = 1000;
  localparam longint SEC_PER_MIN    = 60;
  localparam longint FAST_FACTOR    = 1000;
  localparam longint CYC_PER_MS     = CLK_HZ / MS_PER_SEC;
  localparam logic [15:0] MS_CYCLES = 16'(CYC_PER_MS);
  localparam logic [15:0] MS_PER_SEC_W = 16'(MS_PER_SEC);
  localparam logic [15:0] MIN_FACTOR_W = 16'(SEC_PER_MIN);
  // ==========================================================
  // Host I/O cycle carrier
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  data;
  } ipw_io_type;
endpackage

// ==== logic/ipw_tick_gen.sv ====
`timescale 1ns/100ps
// ==========================================================
// Unit tick generator: ms prescaler, then per-second or per-minute
module ipw_tick_gen #(
  parameter logic [15:0] P_MS_CYCLES = ipw_pkg::MS_CYCLES
) (
  input  wire logic I_CLK,
  input  wire logic I_RST,
  input  wire logic i_restart,
  input  wire logic i_minutes,
  input  wire logic i_fast,
  output logic      o_tick
);
  import ipw_pkg::*;

  typedef struct packed {
    logic [15:0] ms_cnt;   // Cycles within one ms
    logic [15:0] sec_cnt;  // Ms within one second
    logic [15:0] min_cnt;  // Seconds (or ms) within a minute step
    logic        tick;
  } ipw_tick_type;

  ipw_tick_type st;
  ipw_tick_type next_st;
  logic ms_done;
  logic base_done;

  // ==========================================================
  // Combinational next state
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    ms_done = (st.ms_cnt == P_MS_CYCLES - 16'h0001);
    base_done = 1'b0;
    if (i_restart) begin
      next_st.ms_cnt = 16'h0000;
      next_st.sec_cnt = 16'h0000;
      next_st.min_cnt = 16'h0000;
    end else begin
      next_st.ms_cnt = ms_done ? 16'h0000 : st.ms_cnt + 16'h0001;
      if (ms_done) begin
        // Fast mode: base step is 1 ms, else 1 s
        if (i_fast) begin
          base_done = 1'b1;
        end else if (st.sec_cnt == MS_PER_SEC_W - 16'h0001) begin
          next_st.sec_cnt = 16'h0000;
          base_done = 1'b1;
        end else begin
          next_st.sec_cnt = st.sec_cnt + 16'h0001;
        end
      end
      if (base_done) begin
        // Minute unit: sixty base steps per tick
        if (!i_minutes) begin
          next_st.tick = 1'b1;
        end else if (st.min_cnt == MIN_FACTOR_W - 16'h0001) begin
          next_st.min_cnt = 16'h0000;
          next_st.tick = 1'b1;
        end else begin
          next_st.min_cnt = st.min_cnt + 16'h0001;
        end
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_tick = st.tick;
endmodule

// ==== logic/ipw_watchdog.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// - Index at 2E, then data at 2F
// - Two consecutive 87 writes unlock configuration
// - Writing AA to index locks
// - Unit select 08 routes watchdog registers
// - Runs only when activate holds 01
// - F5 bit 3 picks seconds or minutes
// - F5 bit 4 ticks thousand times faster
// - Count zero stops, else units to expiry
// - Expiry raises the timeout output
// - Writing count restarts countdown from value
// - F7 bit 6 lets keyboard reload
// - F7 bit 5 forces timeout, self-clears
// - F7 bit 4 reads timeout status
// - F7 bit 7 lets mouse reload
module ipw_watchdog #(
  parameter logic [15:0] P_MS_CYCLES = ipw_pkg::MS_CYCLES
) (
  input  wire logic               I_CLK,
  input  wire logic               I_RST,
  input  wire ipw_pkg::ipw_io_type I_IO,
  input  wire logic               I_KBD_ACT,
  input  wire logic               I_MOUSE_ACT,
  output logic [7:0]              O_RDATA,
  output logic                    O_RVALID,
  output logic                    O_TIMEOUT
);
  import ipw_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic       unlock_half;  // First key byte seen
    logic       cfg_mode;     // Configuration unlocked
    logic [7:0] index;        // Selected register index
    logic [7:0] unit_sel;
    logic [7:0] activate;
    logic [7:0] cnt_cfg;
    logic [7:0] count;        // Programmed count
    logic [7:0] remain;       // Live countdown
    logic       kbd_en;
    logic       mouse_en;
    logic       status;       // Timed out
    logic       timeout;      // Timeout output
    logic [7:0] rdata;
    logic       rvalid;
    logic [1:0] kbd_sync;
    logic [1:0] mouse_sync;
    logic       kbd_prev;
    logic       mouse_prev;
  } ipw_state_type;

  ipw_state_type st;
  ipw_state_type next_st;

  logic idx_wr;          // Write to index port
  logic dat_wr;          // Write to data port
  logic dat_rd;          // Read of data port
  logic supv_sel;        // Watchdog unit selected
  logic running;         // Function enabled and count loaded
  logic restart;         // Countdown restart
  logic tick;            // One counting unit elapsed
  logic kbd_edge;
  logic mouse_edge;

  // Decodes whether an index names one of the watchdog unit registers
  function automatic logic supv_reg(input logic [7:0] idx);
    supv_reg = (idx == IDX_ACTIVATE) || (idx == IDX_CNT_CFG) ||
               (idx == IDX_COUNT) || (idx == IDX_RELOAD);
  endfunction

  // ==========================================================
  // Unit tick generator
  ipw_tick_gen #(
    .P_MS_CYCLES (P_MS_CYCLES)
  ) u_tick (
    .I_CLK     (I_CLK),
    .I_RST     (I_RST),
    .i_restart (restart),
    .i_minutes (st.cnt_cfg[CFG_MIN_BIT]),
    .i_fast    (st.cnt_cfg[CFG_FAST_BIT]),
    .o_tick    (tick)
  );

  // ==========================================================
  // Access decode
  always_comb begin
    idx_wr = I_IO.wr && (I_IO.addr == IDX_PORT_ADDR);
    dat_wr = I_IO.wr && (I_IO.addr == DATA_PORT_ADDR) && st.cfg_mode;
    dat_rd = I_IO.rd && (I_IO.addr == DATA_PORT_ADDR) && st.cfg_mode;
    supv_sel = (st.unit_sel == UNIT_SUPV);
    kbd_edge = st.kbd_sync[1] && !st.kbd_prev;
    mouse_edge = st.mouse_sync[1] && !st.mouse_prev;
    running = (st.activate == ACT_ON) && (st.count != 8'h00);
    // Reload from host write, enabled activity, or while not running
    restart = (dat_wr && supv_sel && st.index == IDX_COUNT) ||
              (st.kbd_en && kbd_edge) ||
              (st.mouse_en && mouse_edge) ||
              !running;
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    // Activity inputs: two flops before any logic
    next_st.kbd_sync = {st.kbd_sync[0], I_KBD_ACT};
    next_st.mouse_sync = {st.mouse_sync[0], I_MOUSE_ACT};
    next_st.kbd_prev = st.kbd_sync[1];
    next_st.mouse_prev = st.mouse_sync[1];

    // Index port: keys or register index
    if (idx_wr) begin
      if (!st.cfg_mode) begin
        // Two back-to-back key writes needed
        next_st.unlock_half = (I_IO.data == KEY_UNLOCK) && !st.unlock_half;
        if (st.unlock_half && I_IO.data == KEY_UNLOCK) begin
          next_st.cfg_mode = 1'b1;
        end
      end else if (I_IO.data == KEY_LOCK) begin
        next_st.cfg_mode = 1'b0;
        next_st.unlock_half = 1'b0;
      end else begin
        next_st.index = I_IO.data;
      end
    end

    // Data port write
    if (dat_wr) begin
      if (st.index == IDX_UNIT_SEL) begin
        next_st.unit_sel = I_IO.data;
      end else if (supv_sel && st.index == IDX_ACTIVATE) begin
        next_st.activate = I_IO.data;
      end else if (supv_sel && st.index == IDX_CNT_CFG) begin
        next_st.cnt_cfg = I_IO.data;
      end else if (supv_sel && st.index == IDX_COUNT) begin
        next_st.count = I_IO.data;
      end else if (supv_sel && st.index == IDX_RELOAD) begin
        next_st.mouse_en = I_IO.data[RLD_MOUSE_BIT];
        next_st.kbd_en = I_IO.data[RLD_KBD_BIT];
      end
    end

    // Data port read
    if (dat_rd) begin
      next_st.rvalid = 1'b1;
      if (st.index == IDX_UNIT_SEL) begin
        next_st.rdata = st.unit_sel;
      end else if (supv_sel && supv_reg(st.index)) begin
        if (st.index == IDX_ACTIVATE) begin
          next_st.rdata = st.activate;
        end else if (st.index == IDX_CNT_CFG) begin
          next_st.rdata = st.cnt_cfg;
        end else if (st.index == IDX_COUNT) begin
          next_st.rdata = st.count;
        end else begin
          // Force bit always reads zero
          next_st.rdata = {st.mouse_en, st.kbd_en, 1'b0, st.status, 4'h0};
        end
      end else begin
        next_st.rdata = 8'h00;
      end
    end

    // Countdown
    if (restart) begin
      next_st.remain = dat_wr && supv_sel && st.index == IDX_COUNT ? I_IO.data : st.count;
    end else if (tick) begin
      next_st.remain = st.remain - 8'h01;
    end

    // Expiry and forced timeout; set wins over status clear
    if (running && !restart && tick && st.remain == 8'h01) begin
      next_st.timeout = 1'b1;
      next_st.status = 1'b1;
    end else if (dat_wr && supv_sel && st.index == IDX_RELOAD &&
                 I_IO.data[RLD_FORCE_BIT]) begin
      next_st.timeout = 1'b1;
      next_st.status = 1'b1;
    end else if (dat_wr && supv_sel && st.index == IDX_RELOAD &&
                 !I_IO.data[RLD_STAT_BIT]) begin
      next_st.status = 1'b0;
      next_st.timeout = 1'b0;
    end else if (dat_wr && supv_sel && st.index == IDX_COUNT) begin
      next_st.timeout = 1'b0;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign O_RDATA = st.rdata;
  assign O_RVALID = st.rvalid;
  assign O_TIMEOUT = st.timeout;

  // ==========================================================
  // Assertions
  unlock_key_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (!st.cfg_mode && idx_wr && I_IO.data == KEY_UNLOCK && st.unlock_half)
      |=> st.cfg_mode)
    else $error("Two unlock keys did not open configuration");
  lock_key_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (st.cfg_mode && idx_wr && I_IO.data == KEY_LOCK) |=> !st.cfg_mode)
    else $error("Lock key did not lock");
  locked_ignore_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (!st.cfg_mode && !idx_wr) |=> ($stable(st.count) && $stable(st.cnt_cfg)))
    else $error("Locked access changed settings");
  unit_route_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (dat_wr && st.unit_sel != UNIT_SUPV && st.index == IDX_COUNT) |=> $stable(st.count))
    else $error("Count written without unit select");
  disabled_quiet_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (st.activate != ACT_ON) |=> (st.status == $past(st.status) || $past(dat_wr)))
    else $error("Timeout while disabled");
  force_out_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (dat_wr && supv_sel && st.index == IDX_RELOAD && I_IO.data[RLD_FORCE_BIT])
      |=> (O_TIMEOUT && st.status))
    else $error("Forced timeout missing");
  count_write_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (dat_wr && supv_sel && st.index == IDX_COUNT) |=> (st.remain == $past(I_IO.data)))
    else $error("Count write did not restart");
  expiry_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (running && !restart && tick && st.remain == 8'h01) |=> ##0 O_TIMEOUT ##1 st.status)
    else $error("Expiry did not raise timeout");
endmodule

// ==== test/ipw_host_model.sv ====
`timescale 1ns/100ps
// ==========================================================
// Host model: I/O cycles on the index and data ports
module ipw_host_model
  import ipw_pkg::*;
(
  input  wire logic       I_CLK,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid,
  output ipw_io_type      o_io
);
  // Idle bus at time zero
  initial o_io = '0;

  // One-cycle write pulse; released lines show the inverse
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge I_CLK) #1;
    o_io = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    @(posedge I_CLK) #1;
    o_io = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
  endtask

  // One-cycle read pulse; answer looked for over two cycles
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
    @(posedge I_CLK) #1;
    o_io = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
    @(posedge I_CLK) #1;
    o_io = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: 8'hff};
    ok = i_rvalid;
    d = i_rdata;
    if (ok !== 1'b1) begin
      @(posedge I_CLK) #1;
      ok = i_rvalid;
      d = i_rdata;
    end
  endtask
endmodule

// ==== test/ipw_watchdog_tb_top.sv ====
`timescale 1ns/100ps
// ==========================================================
// Bench for the indexed-port watchdog
module ipw_watchdog_tb_top;
  import ipw_pkg::*;
  localparam logic [15:0] MSC   = 16'h0004; // Shortened ms prescale
  localparam int          LIMIT = 20000;    // Hang ceiling in cycles
  logic       clk;
  logic       rst;
  logic       kbd;
  logic       mouse;
  ipw_io_type io;
  logic [7:0] rdata;
  logic       rvalid;
  logic       tmo;
  logic [7:0] v;
  logic       ok;
  int         mismatches;
  int         samples_checked;
  int         cyc;
  int         k;

  ipw_watchdog #(.P_MS_CYCLES(MSC)) dut (.I_CLK(clk), .I_RST(rst), .I_IO(io),
    .I_KBD_ACT(kbd), .I_MOUSE_ACT(mouse), .O_RDATA(rdata), .O_RVALID(rvalid),
    .O_TIMEOUT(tmo));
  ipw_host_model host (.I_CLK(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_io(io));

  // ========================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      mismatches++;
      stop_test();
    end
  end

  // ========================================================
  // Helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic rw(input logic [7:0] i, input logic [7:0] d);
    host.wr(IDX_PORT_ADDR, i);
    host.wr(DATA_PORT_ADDR, d);
  endtask
  task automatic rr(input logic [7:0] i, input logic [7:0] exp);
    host.wr(IDX_PORT_ADDR, i);
    host.rd(DATA_PORT_ADDR, v, ok);
    chk({7'h00, ok}, 8'h01, "read answer");
    chk(v, exp, "read data");
  endtask
  task automatic unlock;
    host.wr(IDX_PORT_ADDR, KEY_UNLOCK);
    host.wr(IDX_PORT_ADDR, KEY_UNLOCK);
  endtask
  // Timeout must rise inside the window [lo, hi] cycles from now
  task automatic wait_to(input int lo, input int hi);
    int n;
    for (n = 0; n < hi && tmo !== 1'b1; n++) @(posedge clk) #1;
    chk({7'h00, tmo}, 8'h01, "timeout missing");
    chk({7'h00, n >= lo}, 8'h01, "timeout early");
  endtask
  // No timeout over n cycles; the output latches, so one look suffices
  task automatic quiet(input int n);
    repeat (n) @(posedge clk);
    #1 chk({7'h00, tmo}, 8'h00, "unexpected timeout");
  endtask
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    kbd = 1'b0;
    mouse = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    host.rd(DATA_PORT_ADDR, v, ok);
    chk({7'h00, ok}, 8'h00, "locked read");
    host.wr(IDX_PORT_ADDR, KEY_UNLOCK);
    host.wr(IDX_PORT_ADDR, IDX_COUNT);
    host.wr(IDX_PORT_ADDR, KEY_UNLOCK);
    host.rd(DATA_PORT_ADDR, v, ok);
    chk({7'h00, ok}, 8'h00, "broken key");
    unlock();
    rw(IDX_UNIT_SEL, UNIT_SUPV);
    rr(IDX_ACTIVATE, RST_ACTIVATE);
    rr(IDX_CNT_CFG, RST_CNT_CFG);
    rr(IDX_COUNT, RST_COUNT);
    rr(IDX_RELOAD, RST_RELOAD);
    rr(IDX_UNIT_SEL, UNIT_SUPV);
    // Disabled function does not count
    rw(IDX_CNT_CFG, 8'h10);
    rw(IDX_COUNT, 8'h02);
    quiet(40);
    // Another unit selected: activate write lands elsewhere
    rw(IDX_UNIT_SEL, 8'h07);
    rw(IDX_ACTIVATE, ACT_ON);
    rw(IDX_COUNT, 8'h55);
    rw(IDX_UNIT_SEL, UNIT_SUPV);
    rr(IDX_ACTIVATE, 8'h00);
    rr(IDX_COUNT, 8'h02);
    rw(IDX_ACTIVATE, ACT_ON);
    rw(IDX_COUNT, 8'h03);
    wait_to(8, 16);
    rr(IDX_RELOAD, 8'h10);
    rw(IDX_RELOAD, 8'h00);
    // Service by rewriting the count
    rw(IDX_COUNT, 8'h03);
    repeat (4) begin
      repeat (6) @(posedge clk);
      rw(IDX_COUNT, 8'h03);
    end
    chk({7'h00, tmo}, 8'h00, "serviced");
    wait_to(8, 16);
    // Keyboard and mouse reload, each disabled then enabled
    for (k = 0; k < 4; k++) begin
      rw(IDX_RELOAD, k[0] ? (k[1] ? 8'h80 : 8'h40) : 8'h00);
      rw(IDX_COUNT, 8'h04);
      repeat (8) begin
        repeat (2) @(posedge clk);
        #1 {mouse, kbd} = k[1] ? 2'b10 : 2'b01;
        repeat (3) @(posedge clk);
        #1 {mouse, kbd} = 2'b00;
      end
      chk({7'h00, tmo}, {7'h00, ~k[0]}, "activity reload");
    end
    // Count zero holds, then forced timeout
    rw(IDX_COUNT, 8'h00);
    rw(IDX_RELOAD, 8'h00);
    quiet(30);
    rw(IDX_RELOAD, 8'h20);
    wait_to(0, 3);
    rr(IDX_RELOAD, 8'h10);
    // Fast minutes, then plain seconds
    rw(IDX_RELOAD, 8'h00);
    rw(IDX_CNT_CFG, 8'h18);
    rw(IDX_COUNT, 8'h01);
    wait_to(236, 246);
    rw(IDX_RELOAD, 8'h00);
    rw(IDX_CNT_CFG, 8'h00);
    rw(IDX_COUNT, 8'h01);
    wait_to(3996, 4006);
    // Lock: data writes and reads ignored
    rw(IDX_COUNT, 8'h00);
    host.wr(IDX_PORT_ADDR, KEY_LOCK);
    rw(IDX_COUNT, 8'h55);
    host.rd(DATA_PORT_ADDR, v, ok);
    chk({7'h00, ok}, 8'h00, "read after lock");
    unlock();
    rr(IDX_COUNT, 8'h00);
    stop_test();
  end
endmodule
